/* File: crs_defs.svh */
// timing constants for the sensor readout timing sequencer
// Notes on behaviour
// - transfer pulse lasts at least 6 us
// - both pedestals last at least 16 us
// - 4 us transfer delay, 10 us line transfer
// - 5 us after toggling line dump gate
// - 1 us before horizontal clocking starts
// - pixel shift period at least 16.66 ns
// - shutter pulse and shutter delay 1 us
// - reset gate pulse at least 2.5 ns
// - line period 104.2 or 192.2 us
// - frame period minimum per readout mode
// - pin patterns chosen by readout mode
// - top phases swap in dual ab, single
// - pixel gates patterns five, six, seven
// - unused output gates may sit high
// - slow c/d clock is integer multiple
// - 2460 or 4920 lines per frame
// - minimum pixels per line per mode
// - 5292 or 10572 pixel counts required
// - vertical rises lead or meet falls
// - optional shutter starts integration time
// - optional line dumps raise frame rate; here each read line gets extra dump transfers, so frames get longer
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH
`define CRS_CLK_MHZ        10
`define CRS_T_PD_US        6
`define CRS_T_PED_US       16
`define CRS_T_D_US         4
`define CRS_T_V_US         10
`define CRS_T_FDG_US       5
`define CRS_T_HS_US        1
`define CRS_T_SUB_US       1
`define CRS_T_HD_US        1
`define CRS_T_LINE_DQ_NS   104200
`define CRS_T_LINE_S_NS    192200
`define CRS_T_FRM_Q_US     256400
`define CRS_T_FRM_D_US     512700
`define CRS_T_FRM_S_US     945700
`define CRS_LINES_HALF     13'd2460
`define CRS_LINES_FULL     13'd4920
`define CRS_PIX_SHORT      14'd5292
`define CRS_PIX_LONG       14'd10572
`define CRS_MODE_QUAD      2'd0
`define CRS_MODE_DUAL_AB   2'd1
`define CRS_MODE_DUAL_AC   2'd2
`define CRS_MODE_SINGLE    2'd3
`endif

/* File: crs_fifo.sv */
// small valid/ready fifo for frame commands
`timescale 1ns/1ps
module crs_fifo #(
   parameter int WIDTH = 7,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // write side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // read side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   logic             wr;
   logic             rd;
   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rp_r];
   assign wr        = in_valid && in_ready;
   assign rd        = out_valid && out_ready;
   always_ff @(posedge mclk) begin
      if (wr) begin
         mem_r[wp_r] <= in_data;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (wr) begin
            wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         end
         if (rd) begin
            rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
      end
   end
endmodule : crs_fifo

/* File: crs_pkg.sv */
// types for the sensor readout timing sequencer
package crs_pkg;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_SHUT  = 4'b0001,
      ST_SHDL  = 4'b0010,
      ST_PEDL  = 4'b0011,
      ST_XFER  = 4'b0100,
      ST_PEDT  = 4'b0101,
      ST_VDLY  = 4'b0110,
      ST_VLINE = 4'b0111,
      ST_HDLY  = 4'b1000,
      ST_PIX   = 4'b1001,
      ST_DUMPD = 4'b1010,
      ST_LFILL = 4'b1011
   } crs_state_t;
   typedef struct packed {
      logic       start;
      logic [1:0] mode;
      logic       shutter_en;
      logic [1:0] dump_lines;
      logic       cd_off;
   } crs_cmd_t;
   typedef struct packed {
      logic v1;
      logic v2t;
      logic v3t;
      logic v4t;
      logic v2b;
      logic v3b;
      logic v4b;
      logic sub;
      logic dump;
   } crs_vert_t;
   typedef struct packed {
      logic [3:0] h1;
      logic [3:0] h2;
      logic [3:0] hl;
      logic [3:0] rg;
   } crs_horiz_t;
endpackage : crs_pkg

/* File: crs_sensor_model.sv */
// behavioural model of the image sensor as seen through its gate pins
`timescale 1ns/1ps
module crs_sensor_model
   import crs_pkg::*;
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // sensor gates
   input  crs_vert_t  vert,
   input  crs_horiz_t horiz,
   // observed counts: 0 rows, 1 long v1, 2 shutters, 3 short shutters, 4 integration,
   // 5 dumps, 6 pixels, 7 last gate slips, 8 swap slips, 9 off pixels, 10 c/d clocks
   output int         st [0:10]
);
   // ---------------------------------------------------------------
   // charge movement
   // ---------------------------------------------------------------
   crs_vert_t  vert_r;
   crs_horiz_t horiz_r;
   int         v1_w;
   int         sub_w;
   int         integ_w;
   logic       integ_on;

   always_ff @(posedge mclk) begin
      if (rst) begin
         st       <= '{default: 0};
         vert_r   <= '0;
         horiz_r  <= '0;
         v1_w     <= 0;
         sub_w    <= 0;
         integ_w  <= 0;
         integ_on <= 1'b0;
      end else begin
         vert_r  <= vert;
         horiz_r <= horiz;
         v1_w    <= vert.v1 ? v1_w + 1 : 0;
         sub_w   <= vert.sub ? sub_w + 1 : 0;
         integ_w <= integ_w + 1;
         if (vert_r.v1 && !vert.v1) begin
            st[0] <= st[0] + 1;
            if (v1_w >= 60)
               st[1] <= st[1] + 1;
            if (integ_on) begin
               st[4]    <= integ_w;
               integ_on <= 1'b0;
            end
         end
         if (vert_r.sub && !vert.sub) begin
            st[2]    <= st[2] + 1;
            integ_w  <= 1;
            integ_on <= 1'b1;
            if (sub_w < 10)
               st[3] <= st[3] + 1;
         end
         if (!vert_r.dump && vert.dump)
            st[5] <= st[5] + 1;
         if (horiz_r.hl[0] && !horiz.hl[0]) begin
            st[6] <= st[6] + 1;
            if (&{horiz.h1[3:2], horiz.h2[3:2], horiz.hl[3:2], horiz.rg[3:2]})
               st[9] <= st[9] + 1;
         end
         if (horiz.hl[0] != horiz.h2[0])
            st[7] <= st[7] + 1;
         if (vert.v2t != vert.v4b || vert.v3t != vert.v3b || vert.v4t != vert.v2b)
            st[8] <= st[8] + 1;
         if (horiz_r.hl[3] && !horiz.hl[3])
            st[10] <= st[10] + 1;
      end
   end
endmodule : crs_sensor_model

/* File: crs_sequencer.sv */
// frame, line and pixel timing sequencer driving the sensor gates
`timescale 1ns/1ps
`include "crs_defs.svh"
module crs_sequencer
   import crs_pkg::*;
#(
   parameter int T_FRAME_Q = `CRS_T_FRM_Q_US * `CRS_CLK_MHZ,
   parameter int T_FRAME_D = `CRS_T_FRM_D_US * `CRS_CLK_MHZ,
   parameter int T_FRAME_S = `CRS_T_FRM_S_US * `CRS_CLK_MHZ,
   parameter int T_LINE_DQ = (`CRS_T_LINE_DQ_NS * `CRS_CLK_MHZ + 999) / 1000,
   parameter int T_LINE_S  = (`CRS_T_LINE_S_NS * `CRS_CLK_MHZ + 999) / 1000,
   parameter int LINES_HALF = 2460,
   parameter int LINES_FULL = 4920
) (
   // clock and reset
   input  wire logic  mclk,
   input  wire logic  rst,
   // frame command stream
   input  wire logic  cmd_valid,
   output logic       cmd_ready,
   input  crs_cmd_t   cmd,
   // status
   output logic       busy,
   output logic       frame_done,
   // sensor gates
   output crs_vert_t  vert,
   output crs_horiz_t horiz
);
   // ----------------------------------------------------------
   // cycle counts
   // ----------------------------------------------------------
   localparam int C_PD  = `CRS_T_PD_US * `CRS_CLK_MHZ;
   localparam int C_PED = `CRS_T_PED_US * `CRS_CLK_MHZ;
   localparam int C_D   = `CRS_T_D_US * `CRS_CLK_MHZ;
   localparam int C_V   = `CRS_T_V_US * `CRS_CLK_MHZ;
   localparam int C_FDG = `CRS_T_FDG_US * `CRS_CLK_MHZ;
   localparam int C_HS  = `CRS_T_HS_US * `CRS_CLK_MHZ;
   localparam int C_SUB = `CRS_T_SUB_US * `CRS_CLK_MHZ;
   localparam int C_HD  = `CRS_T_HD_US * `CRS_CLK_MHZ;

   // ----------------------------------------------------------
   // command fifo
   // ----------------------------------------------------------
   logic     q_valid;
   logic     q_ready;
   crs_cmd_t q_cmd;
   crs_cmd_t cur_r;
   crs_fifo #(.WIDTH($bits(crs_cmd_t)), .DEPTH(8)) u_fifo (
      .mclk      (mclk),
      .rst       (rst),
      .in_valid  (cmd_valid),
      .in_ready  (cmd_ready),
      .in_data   (cmd),
      .out_valid (q_valid),
      .out_ready (q_ready),
      .out_data  (q_cmd)
   );

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   function automatic logic [13:0] pix_count(input logic [1:0] m);
      pix_count = (m == `CRS_MODE_SINGLE || m == `CRS_MODE_DUAL_AB) ?
                  `CRS_PIX_LONG : `CRS_PIX_SHORT;
   endfunction : pix_count
   function automatic logic [12:0] line_count(input logic [1:0] m);
      line_count = (m == `CRS_MODE_SINGLE || m == `CRS_MODE_DUAL_AB) ?
                   13'(LINES_FULL) : 13'(LINES_HALF);
   endfunction : line_count
   function automatic logic [31:0] line_min(input logic [1:0] m);
      line_min = (m == `CRS_MODE_SINGLE) ? 32'(T_LINE_S) : 32'(T_LINE_DQ);
   endfunction : line_min
   function automatic logic [31:0] frame_min(input logic [1:0] m);
      case (m)
         `CRS_MODE_QUAD:   frame_min = 32'(T_FRAME_Q);
         `CRS_MODE_SINGLE: frame_min = 32'(T_FRAME_S);
         default:          frame_min = 32'(T_FRAME_D);
      endcase
   endfunction : frame_min

   // ----------------------------------------------------------
   // state machine
   // ----------------------------------------------------------
   crs_state_t  st_r;
   crs_state_t  st_nxt;
   logic [15:0] tm_r;
   logic [13:0] px_r;
   logic [12:0] ln_r;
   logic [1:0]  dmp_r;
   logic [31:0] lt_r;
   logic [31:0] ft_r;
   logic        ph_r;
   logic        tdone;
   logic        pix_end;

   assign tdone   = (tm_r == 16'h0001);
   assign pix_end = ph_r && (px_r == 14'h0001);
   assign q_ready = (st_r == ST_IDLE);
   assign busy    = (st_r != ST_IDLE);

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE:  if (q_valid) st_nxt = q_cmd.shutter_en ? ST_SHUT : ST_PEDL;
         ST_SHUT:  if (tdone) st_nxt = ST_SHDL;
         ST_SHDL:  if (tdone) st_nxt = ST_PEDL;
         ST_PEDL:  if (tdone) st_nxt = ST_XFER;
         ST_XFER:  if (tdone) st_nxt = ST_PEDT;
         ST_PEDT:  if (tdone) st_nxt = ST_VDLY;
         ST_VDLY:  if (tdone) st_nxt = ST_VLINE;
         ST_VLINE: if (tdone) st_nxt = (dmp_r != 2'h0) ? ST_DUMPD : ST_HDLY;
         ST_DUMPD: if (tdone) st_nxt = ST_VLINE;
         ST_HDLY:  if (tdone) st_nxt = ST_PIX;
         ST_PIX:   if (pix_end) st_nxt = ST_LFILL;
         ST_LFILL: begin
            if (lt_r >= line_min(cur_r.mode)) begin
               if (ln_r == 13'h0001) begin
                  st_nxt = (ft_r >= frame_min(cur_r.mode)) ? ST_IDLE : ST_LFILL;
               end else begin
                  st_nxt = ST_VLINE;
               end
            end
         end
         default:  st_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_r <= ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------
   // interval timer
   // ----------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         tm_r <= 16'h0000;
      end else if (st_nxt != st_r || (st_r == ST_VLINE && st_nxt == ST_VLINE && tdone)) begin
         case (st_nxt)
            ST_SHUT:  tm_r <= 16'(C_SUB);
            ST_SHDL:  tm_r <= 16'(C_HD);
            ST_PEDL:  tm_r <= 16'(C_PED);
            ST_XFER:  tm_r <= 16'(C_PD);
            ST_PEDT:  tm_r <= 16'(C_PED);
            ST_VDLY:  tm_r <= 16'(C_D);
            ST_VLINE: tm_r <= 16'(C_V);
            ST_DUMPD: tm_r <= 16'(C_FDG);
            ST_HDLY:  tm_r <= 16'(C_HS);
            default:  tm_r <= 16'h0000;
         endcase
      end else if (tm_r != 16'h0000) begin
         tm_r <= tm_r - 16'h0001;
      end
   end

   // ----------------------------------------------------------
   // frame command, line, dump and elapsed counters
   // ----------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         cur_r <= '0;
      end else if (st_r == ST_IDLE && q_valid) begin
         cur_r <= q_cmd;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ln_r  <= 13'h0000;
         dmp_r <= 2'h0;
      end else begin
         if (st_r == ST_PEDT) begin
            ln_r <= line_count(cur_r.mode);
         end else if (st_r == ST_LFILL && st_nxt == ST_VLINE) begin
            ln_r <= ln_r - 13'h0001;
         end
         // reload before the next line so the dump gate never glitches
         if (st_r == ST_PEDT || st_r == ST_HDLY) begin
            dmp_r <= cur_r.dump_lines;
         end else if (st_r == ST_VLINE && st_nxt == ST_DUMPD) begin
            dmp_r <= dmp_r - 2'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         lt_r <= 32'h0;
         ft_r <= 32'h0;
      end else begin
         lt_r <= (st_nxt == ST_VLINE && st_r != ST_VLINE && st_r != ST_DUMPD) ?
                 32'h1 : lt_r + 32'h1;
         ft_r <= (st_r == ST_IDLE) ? 32'h0 : ft_r + 32'h1;
      end
   end

   // ----------------------------------------------------------
   // pixel clocking: one pixel per two mclk, 200 ns
   // ----------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         ph_r <= 1'b0;
         px_r <= 14'h0000;
      end else if (st_r == ST_HDLY) begin
         ph_r <= 1'b0;
         px_r <= pix_count(cur_r.mode);
      end else if (st_r == ST_PIX) begin
         ph_r <= ~ph_r;
         if (ph_r) begin
            px_r <= px_r - 14'h0001;
         end
      end
   end

   // ----------------------------------------------------------
   // gate outputs
   // ----------------------------------------------------------
   logic ab_mode;
   assign ab_mode = (cur_r.mode == `CRS_MODE_DUAL_AB) || (cur_r.mode == `CRS_MODE_SINGLE);

   // bottom phase next values, shared so top phases copy them in the same cycle
   logic v2b_nxt;
   logic v3b_nxt;
   logic v4b_nxt;
   assign v2b_nxt = (st_nxt == ST_VLINE) && (tm_r <= 16'(C_V/2));
   assign v3b_nxt = (st_nxt == ST_VLINE);
   assign v4b_nxt = (st_nxt == ST_VLINE) && (tm_r > 16'(C_V/4));

   always_ff @(posedge mclk) begin
      if (rst) begin
         vert <= '0;
      end else begin
         vert.v1   <= (st_nxt == ST_XFER) || (st_nxt == ST_VLINE && tm_r > 16'(C_V/2));
         vert.v2b  <= v2b_nxt;
         vert.v3b  <= v3b_nxt;
         vert.v4b  <= v4b_nxt;
         vert.v2t  <= ab_mode ? v4b_nxt : v2b_nxt;
         vert.v3t  <= v3b_nxt;
         vert.v4t  <= ab_mode ? v2b_nxt : v4b_nxt;
         vert.sub  <= (st_nxt == ST_SHUT);
         vert.dump <= (st_nxt == ST_VLINE) && (dmp_r != 2'h0);
      end
   end

   logic pix_on;
   logic [3:0] used;
   assign pix_on = (st_r == ST_PIX);
   assign used = (cur_r.cd_off && cur_r.mode != `CRS_MODE_QUAD) ?
                 ((cur_r.mode == `CRS_MODE_DUAL_AC) ? 4'h5 : 4'h3) : 4'hf;

   always_ff @(posedge mclk) begin
      if (rst) begin
         horiz <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            horiz.h1[i] <= used[i] ? (pix_on && !ph_r) : 1'b1;
            horiz.h2[i] <= used[i] ? (!pix_on || ph_r) : 1'b1;
            horiz.hl[i] <= used[i] ? (!pix_on || ph_r) : 1'b1;
            horiz.rg[i] <= used[i] ? (pix_on && !ph_r) : 1'b1;
         end
      end
   end

   assign frame_done = (st_r == ST_LFILL) && (st_nxt == ST_IDLE);

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   AST_XFER_LEN: assert property (@(posedge mclk) disable iff (rst)
      $rose(vert.v1) && st_r == ST_XFER |-> vert.v1 [*8])
      else $error("transfer pulse too short");
   AST_PED_ORDER: assert property (@(posedge mclk) disable iff (rst)
      st_r == ST_PEDL && st_nxt == ST_XFER |-> ##(C_PD) st_r == ST_XFER ##1 st_r == ST_PEDT)
      else $error("transfer length wrong");
   AST_HDLY: assert property (@(posedge mclk) disable iff (rst)
      st_r == ST_VLINE && st_nxt == ST_HDLY |=> st_r == ST_HDLY [*8])
      else $error("horizontal delay too short");
   AST_PIX_RATE: assert property (@(posedge mclk) disable iff (rst)
      st_r == ST_PIX && !ph_r |=> ph_r)
      else $error("pixel phase stuck");
   AST_DUMP_DLY: assert property (@(posedge mclk) disable iff (rst)
      st_r == ST_VLINE && st_nxt == ST_DUMPD |=> st_r == ST_DUMPD [*8])
      else $error("dump delay too short");
   AST_SUB_LEN: assert property (@(posedge mclk) disable iff (rst)
      st_r == ST_IDLE && st_nxt == ST_SHUT |=> ##1 vert.sub [*8])
      else $error("shutter pulse too short");
   AST_SWAP: assert property (@(posedge mclk) disable iff (rst)
      ab_mode |=> vert.v2t == vert.v4b && vert.v3t == vert.v3b && vert.v4t == vert.v2b)
      else $error("top phase swap wrong");
   AST_LINE_MIN: assert property (@(posedge mclk) disable iff (rst)
      st_r == ST_LFILL && st_nxt != ST_LFILL |-> lt_r >= line_min(cur_r.mode))
      else $error("line too short");
endmodule : crs_sequencer

/* File: testbench.sv */
// self-checking testbench for the readout timing sequencer
`timescale 1ns/1ps
`include "crs_defs.svh"
module testbench
   import crs_pkg::*;
;
   logic       mclk;
   logic       rst;
   logic       cmd_valid;
   logic       cmd_ready;
   logic       busy;
   logic       frame_done;
   crs_cmd_t   cmd;
   crs_vert_t  vert;
   crs_horiz_t horiz;
   int         st [0:10];
   int         s0 [0:10];
   int         err_total;
   int         num_checks;
   localparam int LN_HALF = 2;
   localparam int LN_FULL = 1;

   // ---------------------------------------------------------------
   // design, sensor and clock
   // ---------------------------------------------------------------
   crs_sequencer #(
      .T_FRAME_Q  (100),
      .T_FRAME_D  (100),
      .T_FRAME_S  (100),
      .LINES_HALF (LN_HALF),
      .LINES_FULL (LN_FULL)
   ) uut (
      .mclk       (mclk),
      .rst        (rst),
      .cmd_valid  (cmd_valid),
      .cmd_ready  (cmd_ready),
      .cmd        (cmd),
      .busy       (busy),
      .frame_done (frame_done),
      .vert       (vert),
      .horiz      (horiz)
   );

   crs_sensor_model sensor (
      .mclk  (mclk),
      .rst   (rst),
      .vert  (vert),
      .horiz (horiz),
      .st    (st)
   );

   always #50 mclk = ~mclk;

   // ---------------------------------------------------------------
   // compare and closing tasks
   // ---------------------------------------------------------------
   task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_eq

   task automatic check_ge(input int got, input int lim);
      num_checks++;
      if (!(got >= lim)) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lim);
      end
   endtask : check_ge

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic test_fill;
      int k;
      k = 0;
      cmd       = {1'b0, `CRS_MODE_QUAD, 1'b0, 2'd0, 1'b0};
      cmd_valid = 1'b1;
      while (cmd_ready === 1'b1 && k < 12) begin
         k++;
         @(negedge mclk);
      end
      cmd_valid = 1'b0;
      check_ge(k, 8);
      check_ge(9, k);
      check_eq(cmd_ready, 1'b0);
      rst = 1'b1;
      repeat (20) @(negedge mclk);
      check_eq(vert, '0);
      check_eq(horiz, '0);
      check_eq(busy, 1'b0);
      check_eq(cmd_ready, 1'b1);
      rst = 1'b0;
      @(negedge mclk);
      $display("test fill and reset done");
   endtask : test_fill

   task automatic run_frame(input logic [1:0] m, input logic sh, input logic [1:0] dl,
                            input logic cdo);
      int n;
      int tl;
      int d [0:10];
      logic swap;
      int lines;
      swap = (m == `CRS_MODE_DUAL_AB) || (m == `CRS_MODE_SINGLE);
      lines = swap ? LN_FULL : LN_HALF;
      tl   = (m == `CRS_MODE_SINGLE) ? 1922 : 1042;
      s0   = st;
      check_eq(cmd_ready, 1'b1);
      cmd       = {1'b0, m, sh, dl, cdo};
      cmd_valid = 1'b1;
      @(negedge mclk);
      cmd_valid = 1'b0;
      n = 1;
      while (frame_done !== 1'b1 && n < 30000) begin
         @(negedge mclk);
         n++;
         if (n == 5)
            check_eq(busy, 1'b1);
      end
      check_eq(frame_done, 1'b1);
      for (int i = 0; i < 11; i++)
         d[i] = st[i] - s0[i];
      check_ge(n, 420 + lines * tl + (sh ? 20 : 0));
      check_ge(d[0], 2);
      check_ge(d[1], 1);
      check_ge(d[6], lines * (swap ? 10572 : 5292));
      check_eq(d[2], sh);
      check_eq(d[3], 0);
      if (sh)
         check_ge(st[4], 230);
      check_eq(d[5], lines * dl);
      if (dl == 2'd0)
         check_eq(d[5], 0);
      check_eq(d[7], 0);
      if (swap)
         check_eq(d[8], 0);
      if (swap && cdo)
         check_eq(d[9], d[6]);
      if (m == `CRS_MODE_QUAD)
         check_ge(d[10], 1);
      if (cdo)
         check_eq(d[10], 0);
      repeat (3) @(negedge mclk);
      check_eq(busy, 1'b0);
      $display("test frame mode %0d done", m);
   endtask : run_frame

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      mclk       = 1'b0;
      rst        = 1'b1;
      cmd_valid  = 1'b0;
      cmd        = '0;
      err_total  = 0;
      num_checks = 0;
      repeat (20) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      test_fill;
      run_frame(`CRS_MODE_QUAD, 1'b1, 2'd0, 1'b0);
      run_frame(`CRS_MODE_DUAL_AB, 1'b0, 2'd2, 1'b1);
      run_frame(`CRS_MODE_DUAL_AC, 1'b1, 2'd1, 1'b1);
      run_frame(`CRS_MODE_SINGLE, 1'b0, 2'd0, 1'b1);
      final_report;
   end

   initial begin
      repeat (95000) @(posedge mclk);
      err_total++;
      $display("watchdog expired");
      final_report;
   end
endmodule : testbench
